// ===== tsc_defines.vh
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH
// temperature register values, half-degree lsb
`define TSC_TEMP_MIN        9'h192
`define TSC_TEMP_MAX        9'h0C8
// counter preset for the lowest temperature step
`define TSC_BASE_COUNT      8'h40
// slope accumulator start and step
`define TSC_SLOPE_INIT      8'h40
`define TSC_SLOPE_STEP      8'h01
`define TSC_SLOPE_PERIOD    4'h8
// rom function commands
`define TSC_CMD_READ_ROM    8'h33
`define TSC_CMD_MATCH_ROM   8'h55
`define TSC_CMD_SEARCH_ROM  8'hF0
`define TSC_CMD_SKIP_ROM    8'hCC
`define TSC_CMD_ALARM_SRCH  8'hEC
// memory and control commands
`define TSC_CMD_CONVERT     8'h44
`define TSC_CMD_WRITE_PAD   8'h4E
`define TSC_CMD_READ_PAD    8'hBE
`define TSC_CMD_COPY_PAD    8'h48
`define TSC_CMD_RECALL      8'hB8
// conversion time and its cycle count at 200 mhz
`define TSC_CONV_TIME_MS    200
`define TSC_CLK_MHZ         200
`define TSC_CONV_CYCLES     (`TSC_CONV_TIME_MS * `TSC_CLK_MHZ * 1000)
// power-on trigger values
`define TSC_HIGH_RESET      8'h7F
`define TSC_LOW_RESET       8'h80
`endif

// ===== tsc_sensor_counter.v
// Behaviour
// R1 - conversion start presets counter and temperature
// R2 - counter zero in open gate increments temperature
// R3 - reload counter from slope on each zero
// R4 - slope changes counts per degree step
// R5 - result in half-degree nine-bit two's complement
// R6 - sixteen-bit result with sign extended
// R7 - span minus 55 to plus 100
// R8 - residual and slope kept after gate
// R9 - memory commands refused before rom command
// R10 - bytes shift least significant bit first
// R11 - master drives strong pull-up during conversion
// R12 - finished result placed in scratchpad
// R13 - high and low triggers stored, readable
// R14 - conversion takes about 0.2 seconds
// R15 - alarm compares integer part with triggers
// R16 - convert command starts, gate end finishes
`timescale 1ns/100ps
`default_nettype none
`include "tsc_defines.vh"
module tsc_sensor_counter #(
  parameter GATE_CYCLES = `TSC_CONV_CYCLES
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // bit stream from the bus bit-slot logic
  input  wire        bit_valid,
  input  wire        bit_value,
  input  wire        bus_reset,
  // oscillator ticks, asynchronous levels
  input  wire        osc_low_tc,
  // outgoing read bit request
  input  wire        rd_bit_req,
  output reg         rd_bit_r,
  // state
  output reg  [15:0] temperature_r,
  output reg  [7:0]  residual_tick_count_r,
  output reg  [7:0]  counts_per_degree_r,
  output reg  [7:0]  high_alarm_trigger_r,
  output reg  [7:0]  low_alarm_trigger_r,
  output reg         alarm_flag_r,
  output reg         converting_r,
  output reg         cmd_refused_r
);
  // command stages: rom, function, trigger write, done
  localparam ST_ROM  = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_WR   = 2'h2;
  localparam ST_IDLE = 2'h3;

  reg [1:0]  state_r;
  reg [7:0]  shift_r;
  reg [2:0]  bit_cnt_r;
  reg [5:0]  rd_idx_r;
  reg [4:0]  wr_idx_r;
  reg [8:0]  temp_r;
  reg [7:0]  down_r;
  reg [7:0]  slope_r;
  reg [3:0]  step_cnt_r;
  reg [31:0] gate_r;
  reg        osc_s1_r;
  reg        osc_s2_r;
  reg        osc_s3_r;
  wire [7:0] byte_in;
  wire       byte_done;
  wire       osc_tick;
  wire [71:0] pad;

  // rom command decoding
  function is_rom_cmd;
    input [7:0] c;
    begin
      is_rom_cmd = (c == `TSC_CMD_READ_ROM) || (c == `TSC_CMD_MATCH_ROM) ||
                   (c == `TSC_CMD_SEARCH_ROM) || (c == `TSC_CMD_SKIP_ROM) ||
                   (c == `TSC_CMD_ALARM_SRCH);
    end
  endfunction

  // new bit enters from the top, lsb arrives first
  assign byte_in   = {bit_value, shift_r[7:1]}; // R10
  assign byte_done = bit_valid && (bit_cnt_r == 3'h7);
  assign osc_tick  = osc_s2_r && !osc_s3_r;
  // scratchpad image, byte 0 first
  assign pad = {8'hFF, counts_per_degree_r, residual_tick_count_r,
                8'hFF, 8'hFF, low_alarm_trigger_r, high_alarm_trigger_r,
                temperature_r}; // R12 R13

  // oscillator synchroniser and edge detect
  // third stage only serves the rising-edge compare
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_low_tc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // command sequencing and scratchpad access
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r              <= ST_ROM;
      shift_r              <= 8'h00;
      bit_cnt_r            <= 3'h0;
      rd_idx_r             <= 6'h3F;
      wr_idx_r             <= 5'h00;
      rd_bit_r             <= 1'b0;
      cmd_refused_r        <= 1'b0;
      high_alarm_trigger_r <= `TSC_HIGH_RESET;
      low_alarm_trigger_r  <= `TSC_LOW_RESET;
    end else if (bus_reset) begin
      // drop a partial byte, a pending read and a refusal pulse
      state_r   <= ST_ROM;
      bit_cnt_r <= 3'h0;
      rd_idx_r  <= 6'h3F;
      cmd_refused_r <= 1'b0;
    end else begin
      cmd_refused_r <= 1'b0;
      // read bits go out lsb first
      if (rd_bit_req && rd_idx_r < 6'h3F) begin
        rd_bit_r <= pad[{1'b0, rd_idx_r} + 7'h00]; // R10
        rd_idx_r <= rd_idx_r + 6'h01;
      end
      if (bit_valid) begin
        shift_r   <= byte_in;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (byte_done) begin
        case (state_r)
          ST_ROM: begin
            // anything but a rom command keeps the rom stage
            if (is_rom_cmd(byte_in))
              state_r <= ST_CMD; // R9
            else
              cmd_refused_r <= 1'b1; // R9
          end
          ST_CMD: begin
            // copy and recall are taken but change nothing here
            state_r <= ST_IDLE;
            if (byte_in == `TSC_CMD_WRITE_PAD) begin
              state_r  <= ST_WR;
              wr_idx_r <= 5'h00;
            end else if (byte_in == `TSC_CMD_READ_PAD)
              rd_idx_r <= 6'h00; // R12
            else if (byte_in != `TSC_CMD_CONVERT &&
                     byte_in != `TSC_CMD_COPY_PAD &&
                     byte_in != `TSC_CMD_RECALL)
              cmd_refused_r <= 1'b1;
          end
          ST_WR: begin
            // two trigger bytes follow the write command
            if (wr_idx_r == 5'h00)
              high_alarm_trigger_r <= byte_in; // R13
            else
              low_alarm_trigger_r <= byte_in; // R13
            wr_idx_r <= wr_idx_r + 5'h01;
            if (wr_idx_r != 5'h00)
              state_r <= ST_IDLE;
          end
          // bytes after a finished command wait for a bus reset
          default: cmd_refused_r <= 1'b1;
        endcase
      end
    end
  end

  // gated down-counter conversion
  // a tick in the cycle the gate closes is not counted
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      converting_r          <= 1'b0;
      gate_r                <= 32'h0;
      down_r                <= 8'h00;
      slope_r               <= `TSC_SLOPE_INIT;
      step_cnt_r            <= 4'h0;
      temp_r                <= `TSC_TEMP_MIN;
      temperature_r         <= 16'h0000;
      residual_tick_count_r <= 8'h00;
      counts_per_degree_r   <= 8'h00;
      alarm_flag_r          <= 1'b0;
    end else if (!converting_r) begin
      if (byte_done && state_r == ST_CMD &&
          byte_in == `TSC_CMD_CONVERT) begin // R16
        converting_r <= 1'b1;
        gate_r       <= GATE_CYCLES; // R14
        down_r       <= `TSC_BASE_COUNT; // R1
        temp_r       <= `TSC_TEMP_MIN; // R1
        slope_r      <= `TSC_SLOPE_INIT;
        step_cnt_r   <= 4'h0;
      end
    end else if (gate_r == 32'h0) begin
      // gate closed: publish result and keep counters
      converting_r          <= 1'b0; // R16
      temperature_r         <= {{7{temp_r[8]}}, temp_r}; // R5 R6 R12
      residual_tick_count_r <= down_r; // R8
      counts_per_degree_r   <= slope_r; // R8
      // alarm ignores the half-degree bit
      alarm_flag_r <=
        ($signed(temp_r[8:1]) > $signed(high_alarm_trigger_r)) ||
        ($signed(temp_r[8:1]) < $signed(low_alarm_trigger_r)); // R15
    end else begin
      gate_r <= gate_r - 32'h1;
      if (osc_tick) begin
        if (down_r <= 8'h01) begin
          // saturate at the top of the span
          if (temp_r != `TSC_TEMP_MAX)
            temp_r <= temp_r + 9'h001; // R2 R7
          down_r     <= slope_r; // R3
          step_cnt_r <= step_cnt_r + 4'h1;
          if (step_cnt_r == `TSC_SLOPE_PERIOD - 4'h1) begin
            slope_r    <= slope_r + `TSC_SLOPE_STEP; // R4
            step_cnt_r <= 4'h0;
          end
        end else
          down_r <= down_r - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tsc_sensor_counter_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_sensor_counter_monitor #(
  parameter GATE_CYCLES = 2000
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // watched ports
  input wire logic        bit_valid,
  input wire logic [15:0] temperature_r,
  input wire logic [7:0]  residual_tick_count_r,
  input wire logic [7:0]  counts_per_degree_r,
  input wire logic [7:0]  high_alarm_trigger_r,
  input wire logic        alarm_flag_r,
  input wire logic        converting_r,
  input wire logic        cmd_refused_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // length of the open gate
  logic [31:0] gate_r;
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) gate_r <= 32'h0;
    else gate_r <= converting_r ? gate_r + 32'h1 : 32'h0;
  a_sign_extend: assert property (
    temperature_r[15:8] == {8{temperature_r[8]}}) else $error("sign");
  a_span_limit: assert property (
    $signed(temperature_r) >= -110 && $signed(temperature_r) <= 200)
    else $error("span");
  a_gate_length: assert property (
    $fell(converting_r) |-> gate_r >= GATE_CYCLES - 1
      && gate_r <= GATE_CYCLES + 2) else $error("gate");
  a_start_cause: assert property (
    $rose(converting_r) |-> $past(bit_valid) || $past(bit_valid, 2))
    else $error("start");
  a_result_stands: assert property (
    !converting_r && !$past(converting_r) |-> $stable(temperature_r)
      && $stable(residual_tick_count_r) && $stable(counts_per_degree_r))
    else $error("hold");
  a_alarm_refresh: assert property (
    $changed(alarm_flag_r) |-> $past(converting_r)
      || $past(converting_r, 2)) else $error("alarm");
  a_trigger_write: assert property (
    $changed(high_alarm_trigger_r) |-> $past(bit_valid)
      || $past(bit_valid, 2)) else $error("trig");
  a_refuse_pulse: assert property (
    cmd_refused_r |-> ($past(bit_valid) || $past(bit_valid, 2))
      ##1 !cmd_refused_r) else $error("refuse");
endmodule
`default_nettype wire

// ===== tsc_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_bus_master (
  // clock and read answer
  input  wire logic clk_sys,
  input  wire logic rd_bit_r,
  // bit stream toward the device
  output var logic  bit_valid,
  output var logic  bit_value,
  output var logic  bus_reset,
  output var logic  rd_bit_req
);
  initial {bit_valid, bit_value, bus_reset, rd_bit_req} = 4'h0;
  // one byte lsb first, line inverted between bits
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys) {bit_valid, bit_value} = {1'h1, b[i]};
      @(negedge clk_sys) {bit_valid, bit_value} = {1'h0, ~b[i]};
    end
  endtask
  // bus reset, rom command, then one function command
  task automatic cmd(input logic [7:0] rom, fn);
    @(negedge clk_sys) bus_reset = 1'h1;
    @(negedge clk_sys) bus_reset = 1'h0;
    send(rom);
    send(fn);
  endtask
  // read n bits, first one lands in bit 0
  task automatic get(input int n, output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys) rd_bit_req = 1'h1;
      @(negedge clk_sys) rd_bit_req = 1'h0;
      v[i] = rd_bit_r;
    end
  endtask
endmodule
`default_nettype wire

// ===== tsc_sensor_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_sensor_counter_tb;
  localparam int GATE = 2000;
  logic clk_sys = 1'h0, reset = 1'h1, osc_low_tc = 1'h0;
  wire bit_valid, bit_value, bus_reset, rd_bit_req, rd_bit_r;
  wire [15:0] temperature_r;
  wire [7:0] residual_tick_count_r, counts_per_degree_r;
  wire [7:0] high_alarm_trigger_r, low_alarm_trigger_r;
  wire alarm_flag_r, converting_r, cmd_refused_r;
  logic [31:0] v;
  int fails = 0, checks = 0, osc_half = 400, ref_cnt = 0;
  // system clock, free oscillator, sticky refusal
  always #2.5 clk_sys = ~clk_sys;
  always #(osc_half * 5 + 0.3) osc_low_tc = ~osc_low_tc;
  always @(posedge clk_sys) if (cmd_refused_r === 1'h1) ref_cnt <= ref_cnt + 1;
  tsc_sensor_counter #(.GATE_CYCLES(GATE)) i_tsc_sensor_counter (.clk_sys,
    .reset, .bit_valid, .bit_value, .bus_reset, .osc_low_tc, .rd_bit_req,
    .rd_bit_r, .temperature_r, .residual_tick_count_r, .counts_per_degree_r,
    .high_alarm_trigger_r, .low_alarm_trigger_r, .alarm_flag_r,
    .converting_r, .cmd_refused_r);
  tsc_bus_master i_tsc_bus_master (.clk_sys, .rd_bit_r, .bit_valid,
    .bit_value, .bus_reset, .rd_bit_req);
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // power-on triggers, then a function byte with no rom command
  task automatic t_refuse;
    int r0;
    chk("high", 16'(high_alarm_trigger_r), 16'h007F);
    chk("low", 16'(low_alarm_trigger_r), 16'h0080);
    r0 = ref_cnt;
    i_tsc_bus_master.send(8'h44);
    repeat (3) @(negedge clk_sys);
    chk("refused", 16'(ref_cnt - r0), 16'h0001);
    chk("no conv", 16'(converting_r), 16'h0000);
  endtask
  // trigger writes behind each of the five rom commands
  task automatic t_write;
    logic [7:0] roms [5] = '{8'h33, 8'h55, 8'hF0, 8'hCC, 8'hEC};
    int r0;
    r0 = ref_cnt;
    for (int i = 0; i < 5; i++) begin
      i_tsc_bus_master.cmd(roms[i], 8'h4E);
      i_tsc_bus_master.send({4'h1, 4'(i)});
      i_tsc_bus_master.send({4'hE, 4'(i)});
      repeat (3) @(negedge clk_sys);
      chk("high", 16'(high_alarm_trigger_r), {12'h001, 4'(i)});
      chk("low", 16'(low_alarm_trigger_r), {12'h00E, 4'(i)});
    end
    chk("no refusal", 16'(ref_cnt - r0), 16'h0000);
    // copy and recall are accepted and leave the high trigger alone
    i_tsc_bus_master.cmd(8'hCC, 8'h48);
    i_tsc_bus_master.cmd(8'hCC, 8'hB8);
    repeat (3) @(negedge clk_sys);
    chk("copy refused", 16'(ref_cnt - r0), 16'h0000);
    chk("copy high", 16'(high_alarm_trigger_r), 16'h0014);
    // an unknown function byte after a rom command is refused
    i_tsc_bus_master.cmd(8'hCC, 8'h99);
    repeat (3) @(negedge clk_sys);
    chk("bad function", 16'(ref_cnt - r0), 16'h0001);
  endtask
  // start a conversion and wait out the gate
  task automatic conv(input int half);
    osc_half = half;
    i_tsc_bus_master.cmd(8'hCC, 8'h44);
    for (int i = 0; i < 20 && converting_r !== 1'h1; i++) @(negedge clk_sys);
    chk("gate open", 16'(converting_r), 16'h0001);
    // bus stays quiet, as under the strong pull-up
    for (int i = 0; i < GATE + 50 && converting_r === 1'h1; i++)
      @(negedge clk_sys);
    chk("gate end", 16'(converting_r), 16'h0000);
  endtask
  // slow ticks never reach zero: result stays at the preset
  task automatic t_slow;
    int r0;
    conv(400);
    chk("temp", temperature_r, 16'hFF92);
    chk("slope", 16'(counts_per_degree_r), 16'h0040);
    chk("residual", 16'(residual_tick_count_r >= 8'h3C
      && residual_tick_count_r < 8'h40), 16'h0001);
    chk("alarm", 16'(alarm_flag_r), 16'h0001);
    r0 = ref_cnt;
    i_tsc_bus_master.send(8'h44);
    repeat (3) @(negedge clk_sys);
    chk("late byte", 16'(ref_cnt - r0), 16'h0001);
    i_tsc_bus_master.cmd(8'hCC, 8'hBE);
    i_tsc_bus_master.get(32, v);
    chk("pad temp", v[15:0], 16'hFF92);
    chk("pad trig", v[31:16], 16'hE414);
  endtask
  // fast ticks pass eight steps so the slope grows once
  task automatic t_fast;
    i_tsc_bus_master.cmd(8'hCC, 8'h4E);
    i_tsc_bus_master.send(8'h7F);
    i_tsc_bus_master.send(8'h80);
    conv(1);
    chk("steps", 16'(temperature_r > 16'hFF96
      && temperature_r < 16'hFFA4), 16'h0001);
    chk("slope grown", 16'(counts_per_degree_r), 16'h0041);
    chk("alarm", 16'(alarm_flag_r), 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'h0;
    t_refuse;
    t_write;
    t_slow;
    t_fast;
    report_and_stop;
  end
  // cut a hang short
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule
bind tsc_sensor_counter tsc_sensor_counter_monitor #(
  .GATE_CYCLES(GATE_CYCLES)) i_mon (.clk_sys, .reset, .bit_valid,
  .temperature_r, .residual_tick_count_r, .counts_per_degree_r,
  .high_alarm_trigger_r, .alarm_flag_r, .converting_r, .cmd_refused_r);
`default_nettype wire
